// *** pbc_defs.vh ***
// constants and register map of the pll base clock select control
// Behaviour
// R1: programming register holds multiplier in upper four bits, range in lower four
// R2: software picks multiplier and range by rounding frequency ratios
// R3: multiplier value zero configures the feedback divider like one
// R4: range value zero disables the loop and forces crystal clock as base
// R5: source change waits up to three cycles of each clock, output held static
// R6: transition output divided by two for even duty base clock
// R7: base clock select bit chooses crystal or vco clock for base output
// R8: vco clock cannot be selected while loop power bit is clear
// R9: while vco clock selected, loop power bit is forced set and read-only
// R10: power and select never change together; one change per write applied
// R11: oscillator enable input gates both crystal oscillator and loop
// R12: while loop power set, programming register ignores writes
// R13: irq enable read/write, reset zero; unwritable and reads zero in manual mode
// R14: lock change flag sets on each lock toggle; with enable raises irq; here the flag sets only on toggles in auto mode
// R15: lock change flag reads zero in manual mode; reset clears it
// R16: any read of the control register clears the lock change flag; here a read clears it only if its setup snapshot showed it set, and any write clears it
// R17: irq output comes from lock path through flag and enable
// R18: select bit one is vco over two, zero crystal; reset and stop clear
// R19: loop power bit read/write, set by reset
// R20: lock toggle found by comparing synchronized lock with previous sample
`ifndef PBC_DEFS_VH
`define PBC_DEFS_VH
`define PBC_ADDR_CTRL     12'h000
`define PBC_ADDR_PROG     12'h004
`define PBC_PROG_RESET    8'h66
`define PBC_BIT_IE        7
`define PBC_BIT_FLAG      6
`define PBC_BIT_PWR       5
`define PBC_BIT_SEL       4
`define PBC_CTRL_ONES     4'hF
`define PBC_SETTLE_CYC    3'h3
`endif

// *** pbc_sync.v ***
// two-stage synchroniser for a single level
`default_nettype none
module pbc_sync (
	// clock and reset
	input  wire SYS_CLK,
	input  wire SYS_RST,
	// level in and out
	input  wire d_in,
	output wire q_out
);
	reg s1_q;
	reg s2_q;
	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= d_in;
			s2_q <= s1_q;
		end
	end
	assign q_out = s2_q;
endmodule // pbc_sync
`default_nettype wire

// *** pbc_switch.v ***
// transition control and divide-by-two of the base clock
`default_nettype none
`include "pbc_defs.vh"
module pbc_switch (
	// clock and reset
	input  wire SYS_CLK,
	input  wire SYS_RST,
	// source clocks, already synchronous samples
	input  wire xtal_in,
	input  wire vco_in,
	input  wire sel_vco,
	// base clock and status
	output wire base_out,
	output wire busy
);
	reg       cur_q;
	reg [2:0] xcnt_q;
	reg [2:0] vcnt_q;
	reg       xprev_q;
	reg       vprev_q;
	reg       div_q;
	wire      xrise = xtal_in & ~xprev_q;
	wire      vrise = vco_in & ~vprev_q;
	wire      chg   = (sel_vco != cur_q);
	wire      done  = (xcnt_q >= `PBC_SETTLE_CYC) && (vcnt_q >= `PBC_SETTLE_CYC);
	wire      src   = cur_q ? vrise : xrise;
	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			cur_q   <= 1'b0;
			xcnt_q  <= 3'h0;
			vcnt_q  <= 3'h0;
			xprev_q <= 1'b0;
			vprev_q <= 1'b0;
			div_q   <= 1'b0;
		end else begin
			xprev_q <= xtal_in;
			vprev_q <= vco_in;
			if (chg) begin
				// base clock frozen while both sources are counted out
				if (done) begin // R5
					cur_q  <= sel_vco;
					xcnt_q <= 3'h0;
					vcnt_q <= 3'h0;
				end else begin
					if (xrise && xcnt_q < `PBC_SETTLE_CYC)
						xcnt_q <= xcnt_q + 3'h1;
					if (vrise && vcnt_q < `PBC_SETTLE_CYC)
						vcnt_q <= vcnt_q + 3'h1;
				end
			end else begin
				// an aborted request must not leave counts for the next one
				xcnt_q <= 3'h0;
				vcnt_q <= 3'h0;
				if (src)
					div_q <= ~div_q; // R6
			end
		end
	end
	assign base_out = div_q;
	assign busy     = chg;
endmodule // pbc_switch
`default_nettype wire

// *** pbc_top.v ***
// control registers and base clock selection of the pll clock generator
//
// Chosen here: the register offsets and the APB interface to the registers.
`default_nettype none
`include "pbc_defs.vh"
module pbc_top (
	// clock and reset
	input  wire        SYS_CLK,
	input  wire        SYS_RST,
	// apb slave
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	// clock sources and system control
	input  wire        CRYSTAL_CLOCK,
	input  wire        VCO_CLOCK,
	input  wire        OSCILLATOR_ENABLE_IN,
	input  wire        STOP_MODE,
	// from bandwidth control
	input  wire        LOCK_IN,
	input  wire        AUTO_MODE,
	// analog loop control
	output reg  [3:0]  FEEDBACK_DIVIDE,
	output reg  [3:0]  RANGE_SELECT,
	output reg         LOOP_ENABLE,
	output reg         OSC_RUN,
	// outputs
	output reg         BASE_CLOCK_OUT,
	output reg         SWITCH_BUSY,
	output reg         CLOCK_GEN_IRQ
);
	reg  [7:0] prog_q;
	reg        ie_q;
	reg        flag_q;
	reg        pwr_q;
	reg        sel_q;
	reg        lock_prev_q;
	wire       lock_s;
	wire       base_w;
	wire       busy_w;
	wire       wr_en  = PSEL & PENABLE & PWRITE;
	wire       rd_en  = PSEL & PENABLE & ~PWRITE;
	wire       hit_c  = (PADDR == `PBC_ADDR_CTRL);
	wire       hit_p  = (PADDR == `PBC_ADDR_PROG);
	wire       wr_c   = wr_en & hit_c;
	wire       range0 = (prog_q[3:0] == 4'h0);
	wire       toggle = lock_s ^ lock_prev_q;
	wire       flag_v = flag_q & AUTO_MODE;
	wire       ie_v   = ie_q & AUTO_MODE;
	wire       pw_new = PWDATA[`PBC_BIT_PWR];
	wire       sl_new = PWDATA[`PBC_BIT_SEL];
	wire       pw_chg = (pw_new != pwr_q);
	wire       sl_chg = (sl_new != sel_q);
	wire [7:0] ctrl_rd;
	wire [7:0] prog_rd;

	function [3:0] eff_mul;
		input [3:0] m;
		begin
			eff_mul = (m == 4'h0) ? 4'h1 : m;
		end
	endfunction

	pbc_sync u_lock_sync (
		.SYS_CLK (SYS_CLK),
		.SYS_RST (SYS_RST),
		.d_in    (LOCK_IN),
		.q_out   (lock_s)
	);

	pbc_switch u_switch (
		.SYS_CLK (SYS_CLK),
		.SYS_RST (SYS_RST),
		.xtal_in (CRYSTAL_CLOCK),
		.vco_in  (VCO_CLOCK),
		.sel_vco (sel_q & ~range0), // R4 R7
		.base_out(base_w),
		.busy    (busy_w)
	);

	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			prog_q      <= `PBC_PROG_RESET;
			ie_q        <= 1'b0;
			flag_q      <= 1'b0; // R15
			pwr_q       <= 1'b1; // R19
			sel_q       <= 1'b0; // R18
			lock_prev_q <= 1'b0;
		end else begin
			lock_prev_q <= lock_s; // R20
			if (wr_en && hit_p && !pwr_q)
				prog_q <= PWDATA[7:0]; // R1 R12
			if (wr_c && AUTO_MODE)
				ie_q <= PWDATA[`PBC_BIT_IE]; // R13
			// a new toggle beats the read-clear in the same cycle
			if (toggle && AUTO_MODE)
				flag_q <= 1'b1; // R14
			// a read only clears what its setup-cycle snapshot reported
			else if (PSEL && PENABLE && hit_c && (PWRITE || PRDATA[`PBC_BIT_FLAG]))
				flag_q <= 1'b0; // R16
			if (wr_c) begin
				// power change takes priority; select waits for a later write
				if (pw_chg && !sel_q)
					pwr_q <= pw_new; // R9 R10 R19
				else if (sl_chg && !pw_chg && (pwr_q || !sl_new) && !(sl_new && range0))
					sel_q <= sl_new; // R7 R8 R10
			end
			// power stays writable with range zero; only the select is held off
			if (STOP_MODE || range0)
				sel_q <= 1'b0; // R4 R18
		end
	end

	assign ctrl_rd = {ie_v, flag_v, pwr_q | sel_q, sel_q, `PBC_CTRL_ONES}; // R9 R13 R15
	assign prog_rd = prog_q;
	assign PREADY  = 1'b1;
	assign PSLVERR = 1'b0;

	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			PRDATA          <= 32'h0000_0000;
			FEEDBACK_DIVIDE <= 4'h6;
			RANGE_SELECT    <= 4'h6;
			LOOP_ENABLE     <= 1'b0;
			OSC_RUN         <= 1'b0;
			BASE_CLOCK_OUT  <= 1'b0;
			SWITCH_BUSY     <= 1'b0;
			CLOCK_GEN_IRQ   <= 1'b0;
		end else begin
			if (PSEL && !PENABLE && !PWRITE) begin
				if (PADDR == `PBC_ADDR_CTRL)
					PRDATA <= {24'h00_0000, ctrl_rd};
				else if (PADDR == `PBC_ADDR_PROG)
					PRDATA <= {24'h00_0000, prog_rd};
				else
					PRDATA <= 32'h0000_0000;
			end
			FEEDBACK_DIVIDE <= eff_mul(prog_q[7:4]); // R3
			RANGE_SELECT    <= prog_q[3:0];
			LOOP_ENABLE     <= pwr_q & ~range0 & OSCILLATOR_ENABLE_IN; // R4 R11
			OSC_RUN         <= OSCILLATOR_ENABLE_IN; // R11
			BASE_CLOCK_OUT  <= base_w; // R6
			SWITCH_BUSY     <= busy_w; // R5
			CLOCK_GEN_IRQ   <= flag_v & ie_v; // R14 R17
		end
	end
endmodule // pbc_top
`default_nettype wire

// *** pbc_top_asserts.sv ***
// concurrent checks on the pll base clock control ports
`default_nettype none
module pbc_chk (
	input wire logic        SYS_CLK, SYS_RST, PSEL, PENABLE, PWRITE,
	input wire logic        AUTO_MODE, OSCILLATOR_ENABLE_IN, OSC_RUN, LOOP_ENABLE,
	input wire logic        CLOCK_GEN_IRQ, BASE_CLOCK_OUT, SWITCH_BUSY,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic [3:0]  FEEDBACK_DIVIDE, RANGE_SELECT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	wire rd_c = PSEL && PENABLE && !PWRITE && PADDR == 12'h000;
	a_div_nonzero: assert property (FEEDBACK_DIVIDE != 4'h0) else $error("div 0");
	a_range_off: assert property (RANGE_SELECT == 4'h0 |-> !LOOP_ENABLE) else $error("loop");
	a_osc_gate: assert property (!OSCILLATOR_ENABLE_IN |=> !OSC_RUN && !LOOP_ENABLE) else $error("osc");
	a_loop_osc: assert property (LOOP_ENABLE |-> OSC_RUN) else $error("loop osc");
	a_irq_manual: assert property (!AUTO_MODE |=> !CLOCK_GEN_IRQ) else $error("irq");
	a_base_frozen: assert property (SWITCH_BUSY && $past(SWITCH_BUSY) |-> $stable(BASE_CLOCK_OUT))
		else $error("base moved");
	a_switch_bound: assert property ($rose(SWITCH_BUSY) |-> ##[1:100] !SWITCH_BUSY)
		else $error("switch hang");
	a_read_manual: assert property (rd_c && !AUTO_MODE |-> (PRDATA & 32'hFFFF_FFCF) == 32'h0000_000F)
		else $error("ctrl read");
	c_switch: cover property ($rose(SWITCH_BUSY));
	c_irq: cover property ($rose(CLOCK_GEN_IRQ));
	c_range: cover property (RANGE_SELECT == 4'h0);
endmodule // pbc_chk
bind pbc_top pbc_chk i_chk (.*);
`default_nettype wire

// *** pbc_src.sv ***
// source clocks and base clock edge counter
`default_nettype none
module pbc_src (
	input wire logic SYS_CLK, BASE_CLOCK_OUT,
	output logic     xtal, vco,
	output int       rises
);
	timeunit 1ns;
	timeprecision 1ns;
	int   t = 0;
	logic b_q = 1'b0;
	initial begin
		xtal = 0;
		vco = 0;
		rises = 0;
	end
	// kept well below half the system rate, the design samples them
	always @(posedge SYS_CLK) begin
		t <= t + 1;
		xtal <= ((t + 1) % 8) >= 4;
		vco <= ((t + 1) % 6) >= 3;
		b_q <= BASE_CLOCK_OUT;
		if (BASE_CLOCK_OUT === 1'b1 && b_q === 1'b0)
			rises <= rises + 1;
	end
endmodule // pbc_src
`default_nettype wire

// *** pbc_top_tb_top.sv ***
// testbench for the pll base clock select control
`default_nettype none
module pbc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, osc = 1, lock = 0, auto = 0;
	logic        stop = 0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0000_0000, rdv;
	wire  [31:0] prd;
	wire  [3:0]  fdiv;
	wire  [3:0]  rsel;
	wire         prdy, xt, vc, base, busy, irq, osc_run, loop, perr;
	int          fail_count = 0, num_checks = 0, rises, n, i;
	always #25 clk = ~clk;
	pbc_src i_src (.SYS_CLK(clk), .BASE_CLOCK_OUT(base), .xtal(xt), .vco(vc), .rises(rises));
	pbc_top i_dut (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.CRYSTAL_CLOCK(xt), .VCO_CLOCK(vc), .OSCILLATOR_ENABLE_IN(osc), .STOP_MODE(stop),
		.LOCK_IN(lock), .AUTO_MODE(auto), .FEEDBACK_DIVIDE(fdiv), .RANGE_SELECT(rsel),
		.LOOP_ENABLE(loop), .OSC_RUN(osc_run), .BASE_CLOCK_OUT(base),
		.SWITCH_BUSY(busy), .CLOCK_GEN_IRQ(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= {24'h00_0000, d};
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		rdv = prd;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		acc(0, a, 8'h00);
		chk(rdv, {24'h00_0000, e});
	endtask
	// window of 240 cycles, one rise of slack for phase
	task automatic meas(input int e);
		repeat (3) @(posedge clk);
		for (i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
		n = rises;
		repeat (240) @(posedge clk);
		chk({31'h0000_0000, (rises - n > e - 2) && (rises - n < e + 2)}, 32'h0000_0001);
	endtask
	task end_of_test;
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		rd(12'h000, 8'h2F);
		chk({31'h0000_0000, loop}, 32'h0000_0001);
		rd(12'h004, 8'h66);
		acc(1, 12'h004, 8'h05);
		rd(12'h004, 8'h66);
		meas(15);
		acc(1, 12'h000, 8'h00);
		acc(1, 12'h004, 8'h05);
		rd(12'h004, 8'h05);
		chk({28'h000_0000, rsel}, 32'h0000_0005);
		chk({28'h000_0000, fdiv}, 32'h0000_0001);
		acc(1, 12'h000, 8'h10);
		rd(12'h000, 8'h0F);
		acc(1, 12'h000, 8'h30);
		rd(12'h000, 8'h2F);
		acc(1, 12'h000, 8'h30);
		meas(20);
		acc(1, 12'h000, 8'h10);
		rd(12'h000, 8'h3F);
		acc(1, 12'h000, 8'hB0);
		rd(12'h000, 8'h3F);
		auto <= 1;
		acc(1, 12'h000, 8'hB0);
		lock <= 1;
		repeat (6) @(posedge clk);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		rd(12'h000, 8'hFF);
		rd(12'h000, 8'hBF);
		repeat (2) @(posedge clk);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		acc(1, 12'h000, 8'hA0);
		acc(1, 12'h000, 8'h80);
		acc(1, 12'h004, 8'h50);
		acc(1, 12'h000, 8'hA0);
		acc(1, 12'h000, 8'hB0);
		rd(12'h000, 8'hAF);
		chk({31'h0000_0000, loop}, 32'h0000_0000);
		osc <= 0;
		repeat (2) @(posedge clk);
		chk({31'h0000_0000, osc_run}, 32'h0000_0000);
		osc <= 1;
		rd(12'h008, 8'h00);
		chk({31'h0000_0000, perr}, 32'h0000_0000);
		acc(1, 12'h000, 8'h80);
		acc(1, 12'h004, 8'h44);
		acc(1, 12'h000, 8'hA0);
		acc(1, 12'h000, 8'hB0);
		rd(12'h000, 8'hBF);
		stop <= 1;
		repeat (2) @(posedge clk);
		stop <= 0;
		rd(12'h000, 8'hAF);
		end_of_test;
	end
endmodule // pbc_top_tb_top
`default_nettype wire
